//--- rtl/tx_alarm_oh_cfg.svh
// Functional notes
// - Remote fail pin forces K2 bits 6-8 to 110 with ring port off
// - Force bit or auto alarms also insert code
// - Remote fail pin sampled on line clock
// - AIS pin counts only with ring port off
// - AIS fills frame except section overhead
// - AIS pin sampled on line clock
// - Mode input picks alarm pins or ring port
// - Ring marker and data sampled on ring clock
// - Section DCC clock 192 kHz from 216 kHz
// - Section DCC bits sampled into D1-D3
// - Order-wire clock 64 kHz from 72 kHz
// - Section order-wire bits sampled into E1
`ifndef TX_ALARM_OH_CFG_SVH
`define TX_ALARM_OH_CFG_SVH

// ****************************************
// Rates in kHz
// ****************************************
`define CLK_SYS_KHZ 100000
`define DCC_BASE_KHZ 216
`define DCC_AVG_KHZ 192
`define OW_BASE_KHZ 72
`define OW_AVG_KHZ 64

// ****************************************
// Derived counts
// ****************************************
`define DCC_HALF_CYC ((`CLK_SYS_KHZ / `DCC_BASE_KHZ) / 2)
`define OW_HALF_CYC ((`CLK_SYS_KHZ / `OW_BASE_KHZ) / 2)
`define GAP_RATIO (`DCC_BASE_KHZ / (`DCC_BASE_KHZ - `DCC_AVG_KHZ))

// ****************************************
// Codes, ring slots, buffer shape
// ****************************************
`define K2_RF_CODE 3'h6
`define K2_IDLE_CODE 3'h0
`define RING_SLOT_AIS 5'h12
`define RING_SLOT_RF 5'h13
`define OH_FIFO_DEPTH 16
`define OH_FIFO_WIDTH 11

`endif

//--- rtl/tx_alarm_oh_pkg.sv
// ****************************************
// Shared types
// ****************************************
package tx_alarm_oh_pkg;
  // Overhead byte destination
  typedef enum logic [2:0] {OH_D1, OH_D2, OH_D3, OH_E1, OH_F1, OH_E2}
    oh_kind_type;
  // Ring stream parser states
  typedef enum logic {RING_WAIT, RING_SLOTS} ring_state_type;
endpackage : tx_alarm_oh_pkg

//--- rtl/byte_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Overhead byte buffer link
// ****************************************
interface byte_fifo_if #(parameter int WIDTH = 11) ();
  logic push_valid;
  logic push_ready;
  logic [WIDTH-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [WIDTH-1:0] pop_data;
  // Buffer side
  modport buffer(input push_valid, input push_data, input pop_ready,
                 output push_ready, output pop_valid, output pop_data);
  // Filling side
  modport producer(output push_valid, output push_data,
                   input push_ready);
  // Draining side
  modport consumer(input pop_valid, input pop_data, output pop_ready);
endinterface : byte_fifo_if
`default_nettype wire

//--- rtl/oh_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Synchronous FIFO, registered read data
// ****************************************
module oh_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  byte_fifo_if.buffer link
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH]; // Storage words
  logic [AW-1:0] wr_q, wr_d; // Write pointer
  logic [AW-1:0] rd_q, rd_d; // Read pointer
  logic [AW:0] cnt_q, cnt_d; // Words in storage
  logic [WIDTH-1:0] out_q, out_d; // Output register
  logic out_v_q, out_v_d; // Output register holds a word
  logic push; // Word accepted
  logic load; // Storage word moves to output

  // Next pointers, count and output stage
  always_comb begin
    push = link.push_valid && link.push_ready;
    load = (cnt_q != '0) && (!out_v_q || link.pop_ready);
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = load ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    out_d = load ? mem[rd_q] : out_q;
    if (load) begin
      out_v_d = 1'b1;
    end else if (link.pop_ready) begin
      out_v_d = 1'b0;
    end else begin
      out_v_d = out_v_q;
    end
  end

  // State registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      out_q <= '0;
      out_v_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
      out_v_q <= out_v_d;
    end
  end

  // Storage write
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_q] <= link.push_data;
    end
  end

  // Full stalls the filler
  assign link.push_ready = (cnt_q != (AW + 1)'(DEPTH));
  assign link.pop_valid = out_v_q;
  assign link.pop_data = out_q;
endmodule : oh_fifo
`default_nettype wire

//--- rtl/tx_alarm_oh.sv
`timescale 1ns/1ps
`default_nettype none
`include "tx_alarm_oh_cfg.svh"
// ****************************************
// Transmit alarm insertion and overhead ports
// ****************************************
module tx_alarm_oh
  import tx_alarm_oh_pkg::*;
(
  input wire logic clk_sys, // Transmit line clock
  input wire logic reset,
  input wire logic ring_in_clock,
  input wire logic ring_port_en, // Shared pins act as ring port
  input wire logic tx_remote_fail_req, // Shared pin, also ring marker
  input wire logic tx_line_ais_req, // Shared pin, also ring data
  input wire logic force_remote_failure,
  input wire logic auto_remote_failure_en,
  input wire logic rx_los,
  input wire logic rx_lof,
  input wire logic rx_line_ais,
  input wire logic section_dcc_in,
  input wire logic section_orderwire_in,
  input wire logic section_user_channel_in,
  input wire logic line_orderwire_in,
  input wire logic oh_ready,
  output logic section_dcc_clock,
  output logic orderwire_clock,
  output logic [2:0] k2_low_bits,
  output logic remote_fail_insert,
  output logic line_ais_insert,
  output logic oh_valid,
  output logic [2:0] oh_kind,
  output logic [7:0] oh_byte
);

  // ****************************************
  // Helpers
  // ****************************************
  // Half period of a gapped clock channel
  function automatic logic [11:0] half_cyc(input logic ch);
    return ch ? 12'(`OW_HALF_CYC) : 12'(`DCC_HALF_CYC);
  endfunction : half_cyc

  // ****************************************
  // Ring clock domain
  // ****************************************
  logic r_fm_s1_q, r_fm_s2_q; // Marker synchroniser
  logic r_dat_s1_q, r_dat_s2_q; // Data synchroniser
  logic r_fm_prev_q, r_fm_prev_d; // Marker one bit ago
  ring_state_type r_state_q, r_state_d; // Parser state
  logic [4:0] r_slot_q, r_slot_d; // Next bit slot index
  logic r_ais_q, r_ais_d; // Captured send-AIS bit
  logic [1:0] r_word_q, r_word_d; // Published {ais, fail}
  logic r_tog_q, r_tog_d; // Publish toggle

  // Pin synchronisers on the ring clock
  always_ff @(posedge ring_in_clock or posedge reset) begin
    if (reset) begin
      r_fm_s1_q <= 1'b0;
      r_fm_s2_q <= 1'b0;
      r_dat_s1_q <= 1'b0;
      r_dat_s2_q <= 1'b0;
    end else begin
      r_fm_s1_q <= tx_remote_fail_req;
      r_fm_s2_q <= r_fm_s1_q;
      r_dat_s1_q <= tx_line_ais_req;
      r_dat_s2_q <= r_dat_s1_q;
    end
  end

  // Slot parser, marker rise opens slot 0
  always_comb begin
    r_fm_prev_d = r_fm_s2_q;
    r_state_d = r_state_q;
    r_slot_d = r_slot_q;
    r_ais_d = r_ais_q;
    r_word_d = r_word_q;
    r_tog_d = r_tog_q;
    case (r_state_q)
      RING_WAIT: begin
        // Leading edge of the K1 slot
        if (r_fm_s2_q && !r_fm_prev_q) begin
          r_state_d = RING_SLOTS;
          r_slot_d = 5'h01;
        end
      end
      RING_SLOTS: begin
        r_slot_d = r_slot_q + 5'h01;
        if (r_slot_q == `RING_SLOT_AIS) begin
          r_ais_d = r_dat_s2_q;
        end
        // Last wanted slot, hand word over
        if (r_slot_q == `RING_SLOT_RF) begin
          r_word_d = {r_ais_q, r_dat_s2_q};
          r_tog_d = !r_tog_q;
          r_state_d = RING_WAIT;
        end
      end
      default: begin
        r_state_d = RING_WAIT;
      end
    endcase
  end

  // Parser registers
  always_ff @(posedge ring_in_clock or posedge reset) begin
    if (reset) begin
      r_fm_prev_q <= 1'b0;
      r_state_q <= RING_WAIT;
      r_slot_q <= 5'h00;
      r_ais_q <= 1'b0;
      r_word_q <= 2'h0;
      r_tog_q <= 1'b0;
    end else begin
      r_fm_prev_q <= r_fm_prev_d;
      r_state_q <= r_state_d;
      r_slot_q <= r_slot_d;
      r_ais_q <= r_ais_d;
      r_word_q <= r_word_d;
      r_tog_q <= r_tog_d;
    end
  end

  // ****************************************
  // Line clock domain: synchronisers
  // ****************************************
  logic rf_s1_q, rf_s2_q; // Remote fail pin
  logic ais_s1_q, ais_s2_q; // AIS pin
  logic [3:0] ser_s1_q, ser_s2_q; // Serial inputs {low,suc,sow,dcc}
  logic tog_s1_q, tog_s2_q, tog_s3_q; // Ring toggle crossing
  logic [1:0] ring_word_q, ring_word_d; // Ring {ais, fail} here

  // Two flops on the alarm and serial pins
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rf_s1_q <= 1'b0;
      rf_s2_q <= 1'b0;
      ais_s1_q <= 1'b0;
      ais_s2_q <= 1'b0;
      ser_s1_q <= 4'h0;
      ser_s2_q <= 4'h0;
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end else begin
      rf_s1_q <= tx_remote_fail_req;
      rf_s2_q <= rf_s1_q;
      ais_s1_q <= tx_line_ais_req;
      ais_s2_q <= ais_s1_q;
      ser_s1_q <= {line_orderwire_in, section_user_channel_in,
                   section_orderwire_in, section_dcc_in};
      ser_s2_q <= ser_s1_q;
      tog_s1_q <= r_tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  // Ring word is steady once its toggle lands
  always_comb begin
    ring_word_d = (tog_s2_q != tog_s3_q) ? r_word_q : ring_word_q;
  end

  // ****************************************
  // Alarm insertion
  // ****************************************
  logic rf_ins_q, rf_ins_d; // Remote failure insert
  logic ais_ins_q, ais_ins_d; // Line AIS insert
  logic [2:0] k2_q, k2_d; // K2 bits 6 to 8
  logic auto_rf; // Receive defect driven request

  // Alarm source selection
  always_comb begin
    auto_rf = auto_remote_failure_en && (rx_los || rx_lof || rx_line_ais);
    if (ring_port_en) begin
      // Pins belong to the ring port
      rf_ins_d = ring_word_q[0];
      ais_ins_d = ring_word_q[1];
    end else begin
      rf_ins_d = rf_s2_q;
      ais_ins_d = ais_s2_q;
    end
    rf_ins_d = rf_ins_d || force_remote_failure || auto_rf;
    k2_d = rf_ins_d ? `K2_RF_CODE : `K2_IDLE_CODE;
  end

  // Alarm registers; AIS flag tells the framer to fill ones
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ring_word_q <= 2'h0;
      rf_ins_q <= 1'b0;
      ais_ins_q <= 1'b0;
      k2_q <= `K2_IDLE_CODE;
    end else begin
      ring_word_q <= ring_word_d;
      rf_ins_q <= rf_ins_d;
      ais_ins_q <= ais_ins_d;
      k2_q <= k2_d;
    end
  end

  // ****************************************
  // Gapped clocks and serial capture
  // ****************************************
  logic [1:0][11:0] div_q, div_d; // Half period timers
  logic [1:0][3:0] pos_q, pos_d; // Pulse slot within gap cycle
  logic [1:0] ck_q, ck_d; // Clock levels {ow, dcc}
  logic [1:0] rise; // Rising edge issued now
  logic [1:0] blk; // Channel waits on the buffer
  logic [7:0] dcc_sh_q, dcc_sh_d; // DCC shifter
  logic [2:0] dcc_cnt_q, dcc_cnt_d; // DCC bit count
  logic [2:0][7:0] ow_sh_q, ow_sh_d; // {low, suc, sow} shifters
  logic [2:0] ow_cnt_q, ow_cnt_d; // Order-wire bit count
  logic [1:0] dcc_kind_q, dcc_kind_d; // Next D byte number
  logic [3:0] pend_q, pend_d; // Bytes waiting {e2,f1,e1,dcc}
  logic [3:0][7:0] hold_q, hold_d; // Waiting bytes

  byte_fifo_if #(.WIDTH(`OH_FIFO_WIDTH)) link ();

  // Clock timers; full slot stalls the channel
  always_comb begin
    blk = {|pend_q[3:1], pend_q[0]};
    div_d = div_q;
    pos_d = pos_q;
    ck_d = ck_q;
    rise = 2'b00;
    for (int ch = 0; ch < 2; ch++) begin
      if (div_q[ch] != half_cyc(1'(ch)) - 12'h001) begin
        div_d[ch] = div_q[ch] + 12'h001;
      end else if (ck_q[ch]) begin
        div_d[ch] = 12'h000;
        ck_d[ch] = 1'b0;
      end else if (!blk[ch]) begin
        div_d[ch] = 12'h000;
        // Drop one pulse in each gap cycle
        if (pos_q[ch] == 4'(`GAP_RATIO - 1)) begin
          // Missing pulse holds the line low a whole period
          div_d[ch] = 12'h000 - half_cyc(1'(ch));
          pos_d[ch] = 4'h0;
        end else begin
          pos_d[ch] = pos_q[ch] + 4'h1;
          ck_d[ch] = 1'b1;
          rise[ch] = 1'b1;
        end
      end
    end
  end

  // Shifters and byte hand-off
  always_comb begin
    dcc_sh_d = dcc_sh_q;
    dcc_cnt_d = dcc_cnt_q;
    ow_sh_d = ow_sh_q;
    ow_cnt_d = ow_cnt_q;
    pend_d = pend_q;
    hold_d = hold_q;
    dcc_kind_d = dcc_kind_q;
    link.push_valid = |pend_q;
    link.push_data = {OH_E2, hold_q[3]};
    // Sample DCC at the rising edge
    if (rise[0]) begin
      dcc_sh_d = {dcc_sh_q[6:0], ser_s2_q[0]};
      dcc_cnt_d = dcc_cnt_q + 3'h1;
      if (dcc_cnt_q == 3'h7) begin
        pend_d[0] = 1'b1;
        hold_d[0] = dcc_sh_d;
      end
    end
    // Sample order-wire inputs together
    if (rise[1]) begin
      for (int i = 0; i < 3; i++) begin
        ow_sh_d[i] = {ow_sh_q[i][6:0], ser_s2_q[i + 1]};
      end
      ow_cnt_d = ow_cnt_q + 3'h1;
      if (ow_cnt_q == 3'h7) begin
        pend_d[3:1] = 3'h7;
        hold_d[3:1] = ow_sh_d;
      end
    end
    // One waiting byte per cycle, fixed priority
    if (pend_q[0]) begin
      link.push_data = {3'(dcc_kind_q), hold_q[0]};
    end else if (pend_q[1]) begin
      link.push_data = {OH_E1, hold_q[1]};
    end else if (pend_q[2]) begin
      link.push_data = {OH_F1, hold_q[2]};
    end
    if (link.push_ready) begin
      if (pend_q[0]) begin
        pend_d[0] = 1'b0;
        dcc_kind_d = (dcc_kind_q == 2'h2) ? 2'h0 : dcc_kind_q + 2'h1;
      end else if (pend_q[1]) begin
        pend_d[1] = 1'b0;
      end else if (pend_q[2]) begin
        pend_d[2] = 1'b0;
      end else if (pend_q[3]) begin
        // This clear would win over a fresh E2; the stalled clock never makes one
        pend_d[3] = 1'b0;
      end
    end
  end

  // Serial channel registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      div_q <= '0;
      pos_q <= '0;
      ck_q <= 2'b00;
      dcc_sh_q <= 8'h00;
      dcc_cnt_q <= 3'h0;
      ow_sh_q <= '0;
      ow_cnt_q <= 3'h0;
      dcc_kind_q <= 2'h0;
      pend_q <= 4'h0;
      hold_q <= '0;
    end else begin
      div_q <= div_d;
      pos_q <= pos_d;
      ck_q <= ck_d;
      dcc_sh_q <= dcc_sh_d;
      dcc_cnt_q <= dcc_cnt_d;
      ow_sh_q <= ow_sh_d;
      ow_cnt_q <= ow_cnt_d;
      dcc_kind_q <= dcc_kind_d;
      pend_q <= pend_d;
      hold_q <= hold_d;
    end
  end

  // ****************************************
  // Byte buffer and outputs
  // ****************************************
  oh_fifo #(.WIDTH(`OH_FIFO_WIDTH), .DEPTH(`OH_FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .link(link)
  );

  assign link.pop_ready = oh_ready;
  assign oh_valid = link.pop_valid;
  assign oh_kind = link.pop_data[10:8];
  assign oh_byte = link.pop_data[7:0];
  assign section_dcc_clock = ck_q[0];
  assign orderwire_clock = ck_q[1];
  assign k2_low_bits = k2_q;
  assign remote_fail_insert = rf_ins_q;
  assign line_ais_insert = ais_ins_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_k2_pin_code: assert property (
    (!ring_port_en && rf_s2_q) |=> (k2_low_bits == 3'h6))
    else $error("K2 code missing for remote fail pin");
  a_force_code: assert property (
    force_remote_failure |=> (remote_fail_insert && k2_low_bits == 3'h6))
    else $error("Force bit did not insert code");
  a_rf_pin_path: assert property (
    (!ring_port_en && !force_remote_failure && !auto_remote_failure_en &&
     !tx_remote_fail_req)[*4] |=> !remote_fail_insert)
    else $error("Remote fail pin not followed");
  a_ring_masks_pin: assert property (
    (ring_port_en && ring_word_q == 2'h0) |=> !line_ais_insert)
    else $error("AIS pin acted in ring mode");
  a_ais_release: assert property (
    (!ring_port_en && !tx_line_ais_req)[*4] |=> !line_ais_insert)
    else $error("AIS fill held without request");
  a_ais_pin_path: assert property (
    (!ring_port_en && tx_line_ais_req)[*4] |=> line_ais_insert)
    else $error("AIS pin not followed");
  a_ring_selects: assert property (
    (ring_port_en && ring_word_q[1]) |=> line_ais_insert)
    else $error("Ring AIS bit ignored");
  a_dcc_high: assert property (
    $rose(section_dcc_clock) |=> section_dcc_clock[*8])
    else $error("DCC clock high phase too short");
  a_dcc_byte: assert property (
    (rise[0] && dcc_cnt_q == 3'h7) |=> pend_q[0])
    else $error("DCC byte not captured");
  a_ow_high: assert property (
    $rose(orderwire_clock) |=> orderwire_clock[*8])
    else $error("Order-wire clock high phase too short");
  a_ow_bytes: assert property (
    (rise[1] && ow_cnt_q == 3'h7) |=> (pend_q[3:1] == 3'h7))
    else $error("Order-wire bytes not captured");
  a_ring_publish: assert property (
    @(posedge ring_in_clock) disable iff (reset)
    (r_state_q == RING_SLOTS && r_slot_q == 5'h13) |=>
    (r_tog_q != $past(r_tog_q)))
    else $error("Ring word not published");

  c_ring_word: cover property (tog_s2_q != tog_s3_q);
  c_e2_push: cover property (link.push_valid && pend_q == 4'h8);
  c_fifo_stall: cover property (link.push_valid && !link.push_ready);
  c_ais_on: cover property ($rose(line_ais_insert));
endmodule : tx_alarm_oh
`default_nettype wire

//--- testbench/oh_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Overhead sources and mate ring sender
// ****************************************
module oh_far_side #(
  parameter logic [7:0] DCC_PAT = 8'hc5, // Byte on the DCC line
  parameter logic [23:0] OW_PAT = 24'h3a961e // Order-wire, user, line
) (
  input wire logic reset,
  input wire logic section_dcc_clock,
  input wire logic orderwire_clock,
  output logic section_dcc_in,
  output logic section_orderwire_in,
  output logic section_user_channel_in,
  output logic line_orderwire_in,
  output logic ring_in_clock,
  output logic ring_mark,
  output logic ring_data
);
  logic [2:0] dcc_bit; // Bit shown on the DCC line
  logic [2:0] ow_bit; // Bit shown on the order-wire lines
  initial begin
    ring_in_clock = 1'b0;
    ring_mark = 1'b0;
    ring_data = 1'b0;
  end
  // Next bit after each falling edge, MSB first
  always @(negedge section_dcc_clock or posedge reset) begin
    if (reset) begin
      dcc_bit <= 3'h7;
    end else begin
      dcc_bit <= dcc_bit - 3'h1;
    end
  end
  // Same for the three order-wire lines
  always @(negedge orderwire_clock or posedge reset) begin
    if (reset) begin
      ow_bit <= 3'h7;
    end else begin
      ow_bit <= ow_bit - 3'h1;
    end
  end
  assign section_dcc_in = DCC_PAT[dcc_bit];
  assign section_orderwire_in = OW_PAT[16 + dcc_pad(ow_bit)];
  assign section_user_channel_in = OW_PAT[8 + dcc_pad(ow_bit)];
  assign line_orderwire_in = OW_PAT[dcc_pad(ow_bit)];
  // Widen a bit index
  function automatic int dcc_pad(input logic [2:0] b);
    return int'(b);
  endfunction : dcc_pad
  // One ring bit, data set while the clock is low
  task automatic send_bit(input logic m, input logic d);
    ring_mark = m;
    ring_data = d;
    #15 ring_in_clock = 1'b1;
    #15 ring_in_clock = 1'b0;
  endtask : send_bit
  // One frame as a mate's ring output; clock runs only here
  task automatic send_frame(input logic [7:0] k1, input logic [7:0] k2,
                            input logic ais, input logic rf);
    logic [19:0] word;
    word = {k1, k2, 1'b0, 1'b0, ais, rf}; // Slot 0 first
    repeat (2) send_bit(1'b0, ~ring_data);
    // Marker high except the protection failure slot
    for (int i = 19; i >= 0; i--) begin
      send_bit(i != 2, word[i]);
    end
    repeat (8) send_bit(1'b0, 1'b0); // Far-end error slots
    repeat (4) send_bit(1'b0, ~ring_data);
    ring_data = ~ring_data; // Released line shows no stale value
  endtask : send_frame
endmodule : oh_far_side
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Self-checking bench
// ****************************************
module tb_top;
  localparam logic [7:0] DCC_PAT = 8'hc5; // Not bit-symmetric
  localparam logic [23:0] OW_PAT = 24'h3a961e; // E1, F1, E2 bytes
  logic clk_sys, reset, ring_port_en, rf_drv, ais_drv; // Drives
  logic force_remote_failure, auto_remote_failure_en, oh_ready;
  logic rx_los, rx_lof, rx_line_ais, ring_in_clock, ring_mark, ring_data;
  logic dcc_in, sow_in, suc_in, low_in; // Serial sources
  logic section_dcc_clock, orderwire_clock, remote_fail_insert;
  logic line_ais_insert, oh_valid, watch, watch_hit;
  logic [2:0] k2_low_bits, oh_kind;
  logic [7:0] oh_byte;
  int bad_count, checks, cycles;
  // Shared pins: alarm drives or ring sender
  wire logic pin_rf = ring_port_en ? ring_mark : rf_drv;
  wire logic pin_ais = ring_port_en ? ring_data : ais_drv;
  tx_alarm_oh dut (.clk_sys(clk_sys), .reset(reset),
    .ring_in_clock(ring_in_clock), .ring_port_en(ring_port_en),
    .tx_remote_fail_req(pin_rf), .tx_line_ais_req(pin_ais),
    .force_remote_failure(force_remote_failure),
    .auto_remote_failure_en(auto_remote_failure_en), .rx_los(rx_los),
    .rx_lof(rx_lof), .rx_line_ais(rx_line_ais), .section_dcc_in(dcc_in),
    .section_orderwire_in(sow_in), .section_user_channel_in(suc_in),
    .line_orderwire_in(low_in), .oh_ready(oh_ready),
    .section_dcc_clock(section_dcc_clock),
    .orderwire_clock(orderwire_clock), .k2_low_bits(k2_low_bits),
    .remote_fail_insert(remote_fail_insert),
    .line_ais_insert(line_ais_insert), .oh_valid(oh_valid),
    .oh_kind(oh_kind), .oh_byte(oh_byte));
  oh_far_side #(.DCC_PAT(DCC_PAT), .OW_PAT(OW_PAT)) far_side (
    .reset(reset), .section_dcc_clock(section_dcc_clock),
    .orderwire_clock(orderwire_clock), .section_dcc_in(dcc_in),
    .section_orderwire_in(sow_in), .section_user_channel_in(suc_in),
    .line_orderwire_in(low_in), .ring_in_clock(ring_in_clock),
    .ring_mark(ring_mark), .ring_data(ring_data));
  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;
  // Cycle count, hang cut-off, leak watch
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (watch && (remote_fail_insert || line_ais_insert)) begin
      watch_hit <= 1'b1;
    end
    if (cycles == 70000) begin
      bad_count++;
      $display("BAD %0t timeout", $time);
      tally_and_finish();
    end
  end
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  // Pass n edges, then let updates settle
  task automatic edges(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : edges
  // Remote failure and AIS pins, exact lag
  task automatic t_alarm_pins();
    @(posedge clk_sys);
    rf_drv <= 1'b1;
    edges(2);
    chk(8'(remote_fail_insert), 8'h0, "rf early");
    edges(1);
    chk(8'(remote_fail_insert), 8'h1, "rf set");
    chk(8'(k2_low_bits), 8'h6, "k2 code");
    @(posedge clk_sys);
    rf_drv <= 1'b0;
    ais_drv <= 1'b1;
    edges(2);
    chk(8'(line_ais_insert), 8'h0, "ais early");
    edges(1);
    chk(8'(line_ais_insert), 8'h1, "ais set");
    chk(8'(k2_low_bits), 8'h0, "k2 idle");
    @(posedge clk_sys);
    ais_drv <= 1'b0;
    edges(3);
    chk(8'(line_ais_insert), 8'h0, "ais clear");
  endtask : t_alarm_pins
  // Force bit and each auto cause
  task automatic t_force_auto();
    @(posedge clk_sys);
    force_remote_failure <= 1'b1;
    edges(1);
    chk(8'(k2_low_bits), 8'h6, "forced code");
    @(posedge clk_sys);
    force_remote_failure <= 1'b0;
    edges(1);
    chk(8'(remote_fail_insert), 8'h0, "force off");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      {rx_los, rx_lof, rx_line_ais} <= 3'h1 << i;
      auto_remote_failure_en <= 1'b0;
      edges(2);
      chk(8'(remote_fail_insert), 8'h0, "auto off");
      @(posedge clk_sys);
      auto_remote_failure_en <= 1'b1;
      edges(1);
      chk(8'(remote_fail_insert), 8'h1, "auto cause");
      @(posedge clk_sys);
      {rx_los, rx_lof, rx_line_ais} <= 3'h0;
      edges(1);
      chk(8'(remote_fail_insert), 8'h0, "cause gone");
    end
  endtask : t_force_auto
  // One ring frame, then the alarms it carries
  task automatic ring_case(input logic ais, input logic rf);
    @(posedge clk_sys);
    #2;
    far_side.send_frame(8'h5a, 8'ha7, ais, rf);
    edges(30);
    chk(8'(line_ais_insert), 8'(ais), "ring ais");
    chk(8'(remote_fail_insert), 8'(rf), "ring rf");
    chk(8'(k2_low_bits), rf ? 8'h6 : 8'h0, "ring k2");
  endtask : ring_case
  // Ring mode: pins no longer raise alarms
  task automatic t_ring();
    @(posedge clk_sys);
    ring_port_en <= 1'b1;
    watch <= 1'b1;
    ring_case(1'b0, 1'b0); // Marker high, no alarm
    watch <= 1'b0;
    chk(8'(watch_hit), 8'h0, "pin leak");
    ring_case(1'b1, 1'b1);
    ring_case(1'b1, 1'b0);
    ring_case(1'b0, 1'b1);
    ring_case(1'b0, 1'b0);
    @(posedge clk_sys);
    ring_port_en <= 1'b0;
    edges(4);
    chk(8'(line_ais_insert), 8'h0, "pins back");
  endtask : t_ring
  // Buffer full stalls clocks; drain with stalls
  task automatic t_fifo();
    int rs, rd, ro, dn, on, pops;
    logic pd, po;
    rs = 0; rd = 0; ro = 0; dn = 0; on = 0; pops = 0;
    wait (cycles >= 50000);
    pd = section_dcc_clock;
    po = orderwire_clock;
    repeat (3000) begin
      @(posedge clk_sys);
      rs += int'(section_dcc_clock && !pd) + int'(orderwire_clock && !po);
      pd = section_dcc_clock;
      po = orderwire_clock;
    end
    chk(8'(rs), 8'h0, "no stall");
    repeat (4000) begin
      @(posedge clk_sys);
      oh_ready <= cycles[1];
      // Settled values; a word seen with ready pops at the next edge
      #1;
      rd += int'(section_dcc_clock && !pd);
      ro += int'(orderwire_clock && !po);
      pd = section_dcc_clock;
      po = orderwire_clock;
      if (oh_valid === 1'b1 && oh_ready === 1'b1) begin
        pops++;
        if (oh_kind < 3'h3) begin
          chk(8'(oh_kind), 8'(dn % 3), "dcc kind");
          chk(oh_byte, DCC_PAT, "dcc byte");
          dn++;
        end else begin
          chk(8'(oh_kind), 8'(3 + on % 3), "ow kind");
          chk(oh_byte, OW_PAT[23 - 8 * (on % 3) -: 8], "ow byte");
          on++;
        end
      end
    end
    chk(8'(pops >= 16), 8'h1, "too few bytes");
    chk(8'(rd > 0 && ro > 0), 8'h1, "no resume");
  endtask : t_fifo
  // Verdict and end of run
  task automatic tally_and_finish();
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    {clk_sys, ring_port_en, rf_drv, ais_drv, oh_ready} = 5'h0;
    {force_remote_failure, auto_remote_failure_en} = 2'h0;
    {rx_los, rx_lof, rx_line_ais, watch, watch_hit} = 5'h0;
    bad_count = 0;
    checks = 0;
    cycles = 0;
    reset = 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    t_alarm_pins();
    t_force_auto();
    t_ring();
    t_fifo();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
